// file: include/tsq_map.vh
// Constants, register map and timing for the tone sequencer
`ifndef TSQ_MAP_VH
`define TSQ_MAP_VH

// Register byte addresses
`define TSQ_ADDR_W 8
`define TSQ_OFF_CTRL 8'h00
`define TSQ_OFF_TUNE_LEN 8'h04
`define TSQ_OFF_TBL_ADDR 8'h08
`define TSQ_OFF_TBL_DATA 8'h0c
`define TSQ_OFF_STATUS 8'h10

// Control register fields
`define TSQ_CTRL_FAST 0
`define TSQ_CTRL_RESTART 1

// Table entry layout: pitch low byte, length high byte
`define TSQ_ENT_PITCH_LSB 0
`define TSQ_ENT_LEN_LSB 8

// Status register fields
`define TSQ_ST_PLAYING 0
`define TSQ_ST_DONE 1
`define TSQ_ST_SPK_A 2
`define TSQ_ST_SPK_B 3
`define TSQ_ST_IDX_LSB 8

// Table geometry
`define TSQ_IDX_W 5
`define TSQ_TBL_DEPTH 32
`define TSQ_LEN_W 6

// Reset values
`define TSQ_RST_TUNE_LEN 6'h00
`define TSQ_RST_SPK_A 1'b0
`define TSQ_RST_SPK_B 1'b1

// Timing: a loop pass is 20 us; the fast mode halves it (one octave up)
`define TSQ_CLK_NS 40
`define TSQ_PASS_NS 20000
`define TSQ_PASS_CYC (`TSQ_PASS_NS / `TSQ_CLK_NS)
`define TSQ_FAST_CYC (`TSQ_PASS_CYC / 2)
`define TSQ_DIV_W 9
// Last divider count of a pass, sized to the divider
`define TSQ_PASS_LAST 9'h1f3
`define TSQ_FAST_LAST 9'h0f9

`endif

// file: hdl/tsq_tick.v
// Loop pass divider: one-cycle enable at each fixed pass boundary
`default_nettype none
`include "tsq_map.vh"

module tsq_tick (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Control
  input wire fast,
  input wire restart,
  // Pass enable
  output reg tick
);

  reg [`TSQ_DIV_W-1:0] cnt_reg;
  wire [`TSQ_DIV_W-1:0] last_w;

  // Pass length does not depend on pitch or path taken
  assign last_w = fast ? `TSQ_FAST_LAST : `TSQ_PASS_LAST;

  // Counter restarts with each tone so the first pass is full length
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {`TSQ_DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (restart) begin
      cnt_reg <= {`TSQ_DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_reg >= last_w) begin
      cnt_reg <= {`TSQ_DIV_W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // tsq_tick
`default_nettype wire

// file: hdl/tsq_top.v
// Tone sequencer: note table, tone loop and complementary speaker drive
//
// Added by the designer: the plain strobed port and the register offsets.
`default_nettype none
`include "tsq_map.vh"

module tsq_top (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register port
  input wire [`TSQ_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Speaker pair
  output reg speaker_out_a,
  output reg speaker_out_b
);

  // Sequencer states, one-hot
  localparam [2:0] ST_FETCH = 3'h1;
  localparam [2:0] ST_TONE = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // Note table: pitch in the low byte, length in the high byte
  reg [15:0] tbl_mem [0:`TSQ_TBL_DEPTH-1];

  // Software visible state
  reg fast_reg;
  reg [`TSQ_LEN_W-1:0] tune_len_reg;
  reg [`TSQ_IDX_W-1:0] tbl_addr_reg;
  reg restart_reg;

  // Sequencer and tone engine state
  reg [2:0] state_reg;
  reg [`TSQ_IDX_W-1:0] note_idx_reg;
  reg [7:0] pitch_reg;
  reg [7:0] pitch_cnt_reg;
  reg [7:0] length_count_high;
  reg [7:0] length_count_low;
  reg tgl_reg;
  reg tgl_pat_reg;

  wire tick;
  wire [15:0] cur_entry;
  wire [7:0] cur_pitch;
  wire [7:0] cur_length;
  wire notes_left;
  wire pitch_zero_next;
  wire tone_end;
  wire wr_ctrl;
  wire wr_len;
  wire wr_addr;
  wire wr_data;

  // Write decode
  assign wr_ctrl = reg_wr && (reg_addr == `TSQ_OFF_CTRL);
  assign wr_len = reg_wr && (reg_addr == `TSQ_OFF_TUNE_LEN);
  assign wr_addr = reg_wr && (reg_addr == `TSQ_OFF_TBL_ADDR);
  assign wr_data = reg_wr && (reg_addr == `TSQ_OFF_TBL_DATA);

  // Current note fields, looked up by the note pointer
  assign cur_entry = tbl_mem[note_idx_reg];
  assign cur_pitch = cur_entry[`TSQ_ENT_PITCH_LSB +: 8];
  assign cur_length = cur_entry[`TSQ_ENT_LEN_LSB +: 8];
  // Count set by software; entries past it are never played
  assign notes_left = ({1'b0, note_idx_reg} < tune_len_reg);

  // Countdown expires when this pass brings it to zero
  assign pitch_zero_next = (pitch_cnt_reg == 8'h01);
  // Underflow of the 16-bit length counter ends the tone
  assign tone_end = (length_count_low == 8'h00) &&
                    (length_count_high == 8'h00);

  // Pass divider; restarted at every tone start
  tsq_tick u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .fast(fast_reg),
    .restart(state_reg == ST_FETCH),
    .tick(tick)
  );

  // Table write port; pointer auto-increments for burst loading
  always @(posedge mclk) begin
    if (wr_data) begin
      tbl_mem[tbl_addr_reg] <= reg_wdata[15:0];
    end
  end

  // Control registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fast_reg <= 1'b0;
      tune_len_reg <= `TSQ_RST_TUNE_LEN;
      tbl_addr_reg <= {`TSQ_IDX_W{1'b0}};
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_ctrl && reg_wdata[`TSQ_CTRL_RESTART];
      if (wr_ctrl) begin
        fast_reg <= reg_wdata[`TSQ_CTRL_FAST];
      end
      if (wr_len) begin
        tune_len_reg <= reg_wdata[`TSQ_LEN_W-1:0];
      end
      if (wr_addr) begin
        tbl_addr_reg <= reg_wdata[`TSQ_IDX_W-1:0];
      end else if (wr_data) begin
        tbl_addr_reg <= tbl_addr_reg + 1'b1;
      end
    end
  end

  // Sequencer and tone loop
  // Reset lands in FETCH with the pointer at zero; tune length also resets to zero, so FETCH goes to DONE
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_FETCH;
      note_idx_reg <= {`TSQ_IDX_W{1'b0}};
      pitch_reg <= 8'h00;
      pitch_cnt_reg <= 8'h00;
      length_count_high <= 8'h00;
      length_count_low <= 8'h00;
      tgl_reg <= 1'b0;
      tgl_pat_reg <= 1'b0;
      speaker_out_a <= `TSQ_RST_SPK_A;
      speaker_out_b <= `TSQ_RST_SPK_B;
    end else if (restart_reg) begin
      // Software restart sends the player to FETCH at note zero; speaker levels are kept
      state_reg <= ST_FETCH;
      note_idx_reg <= {`TSQ_IDX_W{1'b0}};
      tgl_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_FETCH: begin
          if (notes_left) begin
            // Sample once; table writes mid-tone do not disturb it
            pitch_reg <= cur_pitch;
            pitch_cnt_reg <= cur_pitch;
            length_count_high <= cur_length;
            length_count_low <= 8'h00;
            tgl_pat_reg <= (cur_pitch != 8'h00);
            tgl_reg <= (cur_pitch != 8'h00);
            state_reg <= ST_TONE;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_TONE: begin
          if (tick) begin
            // Same toggle on both pins keeps them complementary
            speaker_out_a <= speaker_out_a ^ tgl_reg;
            speaker_out_b <= speaker_out_b ^ tgl_reg;
            pitch_cnt_reg <= pitch_cnt_reg - 1'b1;
            if (pitch_zero_next) begin
              pitch_cnt_reg <= pitch_reg;
              tgl_reg <= tgl_pat_reg;
            end else begin
              tgl_reg <= 1'b0;
            end
            // 256 passes of 20 us give about 5 ms per length unit
            length_count_low <= length_count_low - 1'b1;
            if (length_count_low == 8'h00) begin
              length_count_high <= length_count_high - 1'b1;
            end
            if (tone_end) begin
              note_idx_reg <= note_idx_reg + 1'b1;
              // Pointer wraps after the last slot; a full table must stop
              if (&note_idx_reg) begin
                state_reg <= ST_DONE;
              end else begin
                state_reg <= ST_FETCH;
              end
            end
          end
        end
        ST_DONE: begin
          // Idle until reset or restart; outputs hold their levels
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_FETCH;
        end
      endcase
    end
  end

  // Read data: valid only in the cycle after the read strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TSQ_OFF_CTRL: begin
          reg_rdata <= {31'h00000000, fast_reg};
        end
        `TSQ_OFF_TUNE_LEN: begin
          reg_rdata <= {26'h0000000, tune_len_reg};
        end
        `TSQ_OFF_TBL_ADDR: begin
          reg_rdata <= {27'h0000000, tbl_addr_reg};
        end
        `TSQ_OFF_TBL_DATA: begin
          reg_rdata <= {16'h0000, tbl_mem[tbl_addr_reg]};
        end
        `TSQ_OFF_STATUS: begin
          reg_rdata <= {19'h00000, note_idx_reg, 4'h0,
                        speaker_out_b, speaker_out_a,
                        state_reg == ST_DONE, state_reg == ST_TONE};
        end
        default: begin
          reg_rdata <= 32'h00000000; // Unmapped reads return zero
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // tsq_top
`default_nettype wire

// file: tb/tsq_props.sv
// Port checker for the tone sequencer, bound to its top module
`default_nettype none
`include "tsq_map.vh"
module tsq_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [`TSQ_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Speaker pair
  input wire logic speaker_out_a,
  input wire logic speaker_out_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_reg;
  logic [15:0] gap_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Cycles since the last speaker edge; saturates so it never wraps
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
      gap_reg <= 16'h0;
    end else begin
      prev_reg <= speaker_out_a;
      if (speaker_out_a != prev_reg) gap_reg <= 16'h0;
      else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h1;
    end
  end
  spk_comp_a: assert property (speaker_out_a != speaker_out_b)
    else $error("speaker pins not complementary");
  spk_gap_a: assert property (speaker_out_a != prev_reg |-> gap_reg >= 16'd240)
    else $error("speaker edge inside one pass");
  spk_hold_a: assert property ($changed(speaker_out_a) |=> $stable(speaker_out_a) [*8])
    else $error("speaker moved between passes");
  rst_val_a: assert property ($rose(rst_b) |-> !speaker_out_a && speaker_out_b)
    else $error("speaker levels wrong after reset");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  st_spk_a: assert property (reg_rd && reg_addr == `TSQ_OFF_STATUS |=>
    reg_rdata[3:2] == {$past(speaker_out_b), $past(speaker_out_a)})
    else $error("status speaker bits wrong");
  st_excl_a: assert property (reg_rd && reg_addr == `TSQ_OFF_STATUS |=> !(reg_rdata[0] && reg_rdata[1]))
    else $error("playing and done together");
  ctl_rd_a: assert property (reg_rd && reg_addr == `TSQ_OFF_CTRL |=> reg_rdata[31:1] == 31'h0)
    else $error("control readback has stray bits");
endmodule // tsq_props
bind tsq_top tsq_props u_props (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .speaker_out_a(speaker_out_a), .speaker_out_b(speaker_out_b));
`default_nettype wire

// file: tb/tsq_spk_model.sv
// Speaker load model: counts inversions of the pair and their spacing
`default_nettype none
module tsq_spk_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Speaker pair
  input wire logic speaker_out_a,
  input wire logic speaker_out_b,
  // Observations
  output var logic [15:0] flips = 16'h0,
  output var logic [15:0] gap = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_a = 1'b0;
  logic [15:0] cnt = 16'h0;
  // Differential drive: the cone only moves when the pair swaps levels
  always @(posedge mclk) begin
    cnt <= cnt + 16'h1;
    last_a <= speaker_out_a;
    if (rst_b && speaker_out_a != last_a && speaker_out_a != speaker_out_b) begin
      flips <= flips + 16'h1;
      gap <= cnt;
      cnt <= 16'h1;
    end
  end
endmodule // tsq_spk_model
`default_nettype wire

// file: tb/tsq_top_tb_top.sv
// Self-checking bench for the tone sequencer
`default_nettype none
`include "tsq_map.vh"
module tsq_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic spk_a, spk_b;
  wire logic [15:0] flips, gap;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h1232abf8;
  logic [15:0] f0;
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  tsq_top dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .speaker_out_a(spk_a), .speaker_out_b(spk_b));
  tsq_spk_model spk (.mclk(mclk), .rst_b(rst_b), .speaker_out_a(spk_a),
    .speaker_out_b(spk_b), .flips(flips), .gap(gap));
  always #20 mclk = ~mclk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Expected read data is queued here and matched by the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // Hang guard: the long tone needs about 64k cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`TSQ_OFF_STATUS, 32'h0000_000a);
    rd(8'h14, 32'h0);
    rd(`TSQ_OFF_TUNE_LEN, 32'h0);
    wr(`TSQ_OFF_TBL_ADDR, 32'h5);
    wr(`TSQ_OFF_TBL_DATA, rnd());
    wr(`TSQ_OFF_TBL_DATA, (32'd191 * 32'd9442 + 32'd5000) / 32'd10000);
    wr(`TSQ_OFF_TBL_ADDR, 32'h5);
    rd(`TSQ_OFF_TBL_DATA, {16'h0, seed[15:0]});
    wr(`TSQ_OFF_TBL_ADDR, 32'h6);
    rd(`TSQ_OFF_TBL_DATA, 32'd180);
    $display("test 1 done");
    // Short notes: pitch 2, a rest, pitch 1, each one pass long
    wr(`TSQ_OFF_TBL_ADDR, 32'h0);
    wr(`TSQ_OFF_TBL_DATA, 32'd50000 / 32'd16667);
    wr(`TSQ_OFF_TBL_DATA, 32'h0000);
    wr(`TSQ_OFF_TBL_DATA, 32'h0001);
    wr(`TSQ_OFF_TUNE_LEN, 32'h3);
    f0 = flips;
    wr(`TSQ_OFF_CTRL, 32'h2);
    repeat (1700) @(posedge mclk);
    chk(flips - f0, 32'h2);
    rd(`TSQ_OFF_STATUS, 32'h0000_030a);
    $display("test 2 done");
    // One long tone in fast mode: 257 passes of 250 cycles
    wr(`TSQ_OFF_TBL_ADDR, 32'h0);
    wr(`TSQ_OFF_TBL_DATA, 32'h0103);
    wr(`TSQ_OFF_TUNE_LEN, 32'h1);
    f0 = flips;
    wr(`TSQ_OFF_CTRL, 32'h3);
    repeat (64125) @(posedge mclk);
    rd(`TSQ_OFF_STATUS, 32'h0000_0009);
    repeat (260) @(posedge mclk);
    rd(`TSQ_OFF_STATUS, 32'h0000_010a);
    chk(flips - f0, 32'd86);
    chk(gap, 32'd750);
    $display("test 3 done");
    // Reset in mid-tone restores levels and the first note
    wr(`TSQ_OFF_CTRL, 32'h3);
    repeat (300) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`TSQ_OFF_STATUS, 32'h0000_000a);
    repeat (3) @(posedge mclk);
    $display("test 4 done");
    report_and_stop();
  end
endmodule // tsq_top_tb_top
`default_nettype wire
